// File: hdl/bfxu_pkg.sv
// Package: opcodes, condition codes and field constants of the bitfield unit
package bfxu_pkg;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned POS_W      = 5;
    localparam int unsigned WID_W      = 6;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned HALF_W     = 16;
    localparam logic [1:0]  ROT_0      = 2'h0;
    localparam logic [1:0]  ROT_8      = 2'h1;
    localparam logic [1:0]  ROT_16     = 2'h2;
    localparam logic [1:0]  ROT_24     = 2'h3;
    localparam logic [4:0]  ROT_STEP   = 5'h08;

    typedef enum logic [2:0] {
        OP_FIELD_CLEAR  = 3'h0,
        OP_FIELD_INSERT = 3'h1,
        OP_SIGNED_FX    = 3'h2,
        OP_UNSIGNED_FX  = 3'h3,
        OP_BYTE_SIGN    = 3'h4,
        OP_HALF_SIGN    = 3'h5,
        OP_BYTE_ZERO    = 3'h6,
        OP_HALF_ZERO    = 3'h7
    } bfxu_op_e;

    typedef enum logic [3:0] {
        CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2, CC_CC = 4'h3,
        CC_MI = 4'h4, CC_PL = 4'h5, CC_VS = 4'h6, CC_VC = 4'h7,
        CC_HI = 4'h8, CC_LS = 4'h9, CC_GE = 4'ha, CC_LT = 4'hb,
        CC_GT = 4'hc, CC_LE = 4'hd, CC_AL = 4'he, CC_NV = 4'hf
    } bfxu_cond_e;

    // Flag vector order: {n, z, c, v}
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_V = 0;
endpackage

// File: hdl/bfxu_cond_eval.sv
// Condition code evaluation against the core's flags
`timescale 1ns/1ps
module bfxu_cond_eval (
    // Condition and flags
    input  wire logic [3:0] cond_i,
    input  wire logic [3:0] flags_i,
    // Verdict
    output logic            pass_o
);
    logic n, z, c, v;
    always_comb begin
        n = flags_i[bfxu_pkg::FLAG_N];
        z = flags_i[bfxu_pkg::FLAG_Z];
        c = flags_i[bfxu_pkg::FLAG_C];
        v = flags_i[bfxu_pkg::FLAG_V];
        unique case (bfxu_pkg::bfxu_cond_e'(cond_i))
            bfxu_pkg::CC_EQ: pass_o = z;
            bfxu_pkg::CC_NE: pass_o = !z;
            bfxu_pkg::CC_CS: pass_o = c;
            bfxu_pkg::CC_CC: pass_o = !c;
            bfxu_pkg::CC_MI: pass_o = n;
            bfxu_pkg::CC_PL: pass_o = !n;
            bfxu_pkg::CC_VS: pass_o = v;
            bfxu_pkg::CC_VC: pass_o = !v;
            bfxu_pkg::CC_HI: pass_o = c && !z;
            bfxu_pkg::CC_LS: pass_o = !c || z;
            bfxu_pkg::CC_GE: pass_o = (n == v);
            bfxu_pkg::CC_LT: pass_o = (n != v);
            bfxu_pkg::CC_GT: pass_o = !z && (n == v);
            bfxu_pkg::CC_LE: pass_o = z || (n != v);
            // Unconditional; the spare code is treated the same way
            default:         pass_o = 1'b1;
        endcase
    end
endmodule

// File: hdl/bfxu_top.sv
// Bitfield clear/insert/extract and byte/halfword extend datapath
//
// How it works
// [RULE1] Signed extract: selected field sign-extended to 32 bits, written back.
// [RULE2] Unsigned extract: selected field zero-extended to 32 bits, written back.
// [RULE3] Issuer keeps the field low-bit position within 0 to 31.
// [RULE4] Issuer keeps width between 1 and 32 minus the low-bit position.
// [RULE5] No operation of this unit changes the condition flags.
// [RULE6] Issuer never names stack pointer or program counter as operand.
// [RULE7] Optional condition code; operation takes effect only when it holds.
// [RULE8] Extend source rotated right by 0, 8, 16 or 24 bits first.
// [RULE9] Absent rotation operand means no rotation.
// [RULE10] Byte extend variants widen an 8-bit quantity to 32 bits.
// [RULE11] Halfword extend variants widen a 16-bit quantity to 32 bits.
// [RULE12] Byte sign extend: bits 7..0, bit 7 copied into bits 31..8.
// [RULE13] Byte zero extend: bits 7..0, bits 31..8 cleared.
// [RULE14] Halfword sign extend: bits 15..0, bit 15 fills upper half.
// [RULE15] Halfword zero extend: bits 15..0, upper half cleared.
// [RULE16] Clear zeroes width destination bits from low-bit position, rest kept.
// [RULE17] Insert puts source bits from bit 0 into the destination field.
// [RULE18] Result computed in one cycle, presented the cycle after issue.
`timescale 1ns/1ps
module bfxu_top (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Issue
    input  wire logic        issue_i,
    input  wire logic [2:0]  op_i,
    input  wire logic [3:0]  cond_i,
    input  wire logic [3:0]  flags_i,
    input  wire logic [3:0]  dest_idx_i,
    // Operands
    input  wire logic [31:0] source_register_i,
    input  wire logic [31:0] dest_old_i,
    input  wire logic [4:0]  lsb_i,
    input  wire logic [5:0]  width_i,
    input  wire logic [1:0]  rotate_right_amount_i,
    // Write-back
    output logic             wb_en_o,
    output logic [3:0]       wb_idx_o,
    output logic [31:0]      wb_data_o,
    output logic             done_o,
    output logic             skipped_o
);
    typedef struct packed {
        logic        wb_en;
        logic [3:0]  wb_idx;
        logic [31:0] wb_data;
        logic        done;
        logic        skipped;
    } bfxu_state_s;

    bfxu_state_s state_r;
    bfxu_state_s state_nxt;
    logic        cond_pass;

    bfxu_cond_eval u_cond (
        .cond_i  (cond_i),
        .flags_i (flags_i),
        .pass_o  (cond_pass)
    );

    logic [31:0] field_mask;
    logic [31:0] low_mask;
    logic [31:0] shifted;
    logic [31:0] fx_field;
    logic [31:0] sign_bits;
    logic [31:0] rotated;
    logic [4:0]  rot_bits;
    logic [5:0]  top_pos;
    logic [31:0] result;

    // Masks built per bit; width 32 must not overflow a shift
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_mask
            assign low_mask[g] = (6'(g) < width_i);
        end
    endgenerate

    always_comb begin
        field_mask = low_mask << lsb_i;
        shifted    = source_register_i >> lsb_i;
        fx_field   = shifted & low_mask;
        top_pos    = 6'(lsb_i) + width_i - 6'h01;
        // Sign of the field is its top bit in the source [RULE1]
        sign_bits  = source_register_i[top_pos[4:0]] ? ~low_mask : 32'h0;
        rot_bits   = 5'(rotate_right_amount_i) * bfxu_pkg::ROT_STEP; // [RULE8] [RULE9]
        rotated    = (source_register_i >> rot_bits) | (source_register_i << (6'h20 - 6'(rot_bits)));
        if (rot_bits == 5'h00) begin
            rotated = source_register_i; // [RULE9]
        end
        unique case (bfxu_pkg::bfxu_op_e'(op_i))
            bfxu_pkg::OP_FIELD_CLEAR:
                result = dest_old_i & ~field_mask; // [RULE16]
            bfxu_pkg::OP_FIELD_INSERT:
                result = (dest_old_i & ~field_mask)
                       | ((source_register_i << lsb_i) & field_mask); // [RULE17]
            bfxu_pkg::OP_SIGNED_FX:
                result = fx_field | sign_bits; // [RULE1]
            bfxu_pkg::OP_UNSIGNED_FX:
                result = fx_field; // [RULE2]
            bfxu_pkg::OP_BYTE_SIGN:
                result = {{24{rotated[7]}}, rotated[7:0]}; // [RULE10] [RULE12]
            bfxu_pkg::OP_HALF_SIGN:
                result = {{16{rotated[15]}}, rotated[15:0]}; // [RULE11] [RULE14]
            bfxu_pkg::OP_BYTE_ZERO:
                result = {24'h0, rotated[7:0]}; // [RULE10] [RULE13]
            bfxu_pkg::OP_HALF_ZERO:
                result = {16'h0, rotated[15:0]}; // [RULE11] [RULE15]
        endcase
    end

    always_comb begin
        state_nxt         = state_r;
        state_nxt.done    = issue_i; // [RULE18]
        state_nxt.skipped = issue_i && !cond_pass; // [RULE7]
        state_nxt.wb_en   = issue_i && cond_pass; // [RULE7]
        // Data and index held between issues so an idle bus stays quiet
        if (issue_i) begin
            state_nxt.wb_idx  = dest_idx_i;
            state_nxt.wb_data = cond_pass ? result : dest_old_i; // [RULE18]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // No flag output exists: the unit cannot disturb the flags [RULE5]
    assign wb_en_o   = state_r.wb_en;
    assign wb_idx_o  = state_r.wb_idx;
    assign wb_data_o = state_r.wb_data;
    assign done_o    = state_r.done;
    assign skipped_o = state_r.skipped;
endmodule

// File: tb/bfxu_chk.sv
// Port checker of the bitfield unit
`timescale 1ns/1ps
module bfxu_chk (
    // Clock, reset, issue
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        issue_i,
    input wire logic [2:0]  op_i,
    input wire logic [3:0]  cond_i,
    input wire logic [3:0]  flags_i,
    input wire logic [31:0] dest_old_i,
    // Write-back
    input wire logic        wb_en_o,
    input wire logic [31:0] wb_data_o,
    input wire logic        done_o,
    input wire logic        skipped_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    chk_done_each: assert property (issue_i |=> done_o)
        else $error("done missing");
    chk_quiet_idle: assert property (!issue_i |=> !(done_o || wb_en_o || skipped_o))
        else $error("pulse without issue");
    chk_one_verdict: assert property (done_o |-> wb_en_o != skipped_o)
        else $error("verdict clash");
    chk_eq_gate: assert property (issue_i && cond_i == 4'h0 |=> wb_en_o == $past(flags_i[2]))
        else $error("equal gate wrong");
    chk_skip_keep: assert property (issue_i && cond_i == 4'h1 && flags_i[2]
        |=> skipped_o && wb_data_o == $past(dest_old_i)) else $error("skip changed data");
    chk_byte_zero: assert property (issue_i && op_i == 3'h6 && cond_i == 4'he
        |=> wb_data_o[31:8] == 24'h0) else $error("byte upper not clear");
    chk_byte_fill: assert property (issue_i && op_i == 3'h4 && cond_i == 4'he
        |=> wb_data_o[31:8] == {24{wb_data_o[7]}}) else $error("byte sign fill");
    chk_half_fill: assert property (issue_i && op_i == 3'h5 && cond_i == 4'he
        |=> wb_data_o[31:16] == {16{wb_data_o[15]}}) else $error("half sign fill");
    cover property (skipped_o);
    cover property (issue_i && op_i == 3'h2);
    cover property (issue_i ##1 issue_i);
endmodule
bind bfxu_top bfxu_chk i_bfxu_chk (.*);

// File: tb/bfxu_regfile.sv
// Register file stand-in taking the unit's write-backs
`timescale 1ns/1ps
module bfxu_regfile (
    // Clock and write-back
    input  wire logic        ref_clk_i,
    input  wire logic        wb_en_o,
    input  wire logic [3:0]  wb_idx_o,
    input  wire logic [31:0] wb_data_o,
    // Contents
    output logic [31:0]      regs [16]
);
    // Bench keeps indices below 8, away from stack and program counter
    always @(posedge ref_clk_i) if (wb_en_o) regs[wb_idx_o] <= wb_data_o;
endmodule

// File: tb/tb_bfxu_top.sv
// Self-checking bench of the bitfield unit
`timescale 1ns/1ps
module tb_bfxu_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        issue_i = 1'b0;
    logic [2:0]  op_i = 3'h0;
    logic [3:0]  cond_i = 4'he;
    logic [3:0]  flags_i = 4'h0;
    logic [3:0]  dest_idx_i = 4'h0;
    logic [31:0] source_register_i = 32'h0;
    logic [31:0] dest_old_i = 32'h0;
    logic [4:0]  lsb_i = 5'h0;
    logic [5:0]  width_i = 6'h01;
    logic [1:0]  rotate_right_amount_i = 2'h0;
    logic        wb_en_o, done_o, skipped_o;
    logic [3:0]  wb_idx_o;
    logic [31:0] wb_data_o;
    logic [31:0] regs [16];
    int          bad_count = 0;
    int          comparisons = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    bfxu_top i_bfxu_top (.*);
    bfxu_regfile i_bfxu_regfile (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [2:0] op, input logic [3:0] cc, input logic [31:0] s, d,
                       input logic [4:0] l, input logic [5:0] w, input logic [31:0] exp,
                       input logic en);
        @(negedge ref_clk_i);
        {issue_i, op_i, cond_i, source_register_i, dest_old_i} = {1'b1, op, cc, s, d};
        {lsb_i, width_i, dest_idx_i} = {l, w, 1'b0, op};
        @(negedge ref_clk_i);
        issue_i = 1'b0;
        check(wb_data_o, exp);
        check({wb_en_o, skipped_o, done_o}, {en, !en, 1'b1});
        check(wb_idx_o, {29'h0, op});
    endtask
    function automatic logic [31:0] widen(input logic [2:0] op, input logic [31:0] s, int r);
        logic [31:0] v;
        v = (s >> (8 * r)) | (s << (32 - 8 * r));
        case (op)
            3'h4: return {{24{v[7]}}, v[7:0]};
            3'h5: return {{16{v[15]}}, v[15:0]};
            3'h6: return {24'h0, v[7:0]};
            default: return {16'h0, v[15:0]};
        endcase
    endfunction
    task automatic t_extract;
        run(3'h3, 4'he, 32'h12345678, 0, 5'h04, 6'h08, 32'h67, 1);
        run(3'h2, 4'he, 32'h00800000, 0, 5'h14, 6'h04, 32'hfffffff8, 1);
        run(3'h2, 4'he, 32'h80000001, 0, 5'h00, 6'h20, 32'h80000001, 1);
        run(3'h3, 4'he, 32'h80000000, 0, 5'h1f, 6'h01, 32'h1, 1);
    endtask
    task automatic t_clear_insert;
        run(3'h0, 4'he, 0, 32'hffffffff, 5'h08, 6'h0c, 32'hfff000ff, 1);
        run(3'h1, 4'hf, 32'hfffffabc, 0, 5'h08, 6'h0c, 32'h000abc00, 1);
    endtask
    task automatic t_widen;
        for (int o = 4; o < 8; o++) begin
            for (int r = 0; r < 4; r++) begin
                rotate_right_amount_i = 2'(r);
                run(3'(o), 4'he, 32'h80ff017f, 0, 0, 1, widen(3'(o), 32'h80ff017f, r), 1);
            end
        end
        // Later scenarios expect the unrotated low byte
        rotate_right_amount_i = 2'h0;
    endtask
    task automatic t_cond;
        flags_i = 4'h4;
        run(3'h6, 4'h0, 32'h5a, 32'hcafe, 0, 1, 32'h5a, 1);
        run(3'h6, 4'h1, 32'h5a, 32'hcafe, 0, 1, 32'hcafe, 0);
        flags_i = 4'h8;
        run(3'h6, 4'h5, 32'h5a, 32'hcafe, 0, 1, 32'hcafe, 0);
        flags_i = 4'h0;
    endtask
    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_extract;
        t_clear_insert;
        t_widen;
        t_cond;
        check(regs[0], 32'hfff000ff);
        complete_run;
    end
    initial begin
        #2000;
        bad_count++;
        complete_run;
    end
endmodule
